//--- logic/peak_level_latch.sv
// Peak-hold latch for one receive channel strength code.
// Assumes clear and sample strobes synchronous to clk_i.
`timescale 1ns/1ps
module peak_level_latch #(
  parameter int W = 3
) (
  input  wire logic         clk_i,    // Register clock
  input  wire logic         rst_n_i,  // Synchronous reset, active low
  input  wire logic         clear_i,  // Drop the held peak
  input  wire logic         sample_i, // Track the input this cycle
  input  wire logic [W-1:0] level_i,  // Present level code
  output logic      [W-1:0] peak_o    // Held peak code
);

  logic [W-1:0] peak_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clear_i) begin
      peak_reg <= '0;
    end else if (sample_i && (level_i > peak_reg)) begin
      peak_reg <= level_i;
    end
  end

  assign peak_o = peak_reg;

endmodule

//--- logic/reader_status_pkg.sv
// Constants and carrier types for the reader status, test and FIFO status registers.
// Assumes a 125 MHz register clock and an APB slave with 32-bit data.
package reader_status_pkg;

  // ---------------------------------------------------------------
  // Bus and clock
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          CLK_FREQ_MHZ  = 125;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_STRENGTH  = 8'h0f;
  localparam logic [7:0]  IDX_RX_TEST   = 8'h1a;
  localparam logic [7:0]  IDX_CODER     = 8'h1b;
  localparam logic [7:0]  IDX_FIFO      = 8'h1c;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RX_TEST_RST   = 8'h00;
  localparam logic [7:0]  CODER_RST     = 8'h00;

  // ---------------------------------------------------------------
  // Strength register fields
  // ---------------------------------------------------------------
  localparam int          LEVEL_W       = 3;
  localparam int          MAIN_LSB      = 0;
  localparam int          AUX_LSB       = 3;
  localparam int          OSC_OK_BIT    = 6;
  localparam int          LEVEL_STEP_DB = 4;

  // ---------------------------------------------------------------
  // Receiver test register fields
  // ---------------------------------------------------------------
  localparam int          SUBC_IN_BIT   = 7;
  localparam int          SUBC_OUT_BIT  = 6;
  localparam int          DIRECT_BIT    = 5;
  localparam int          STAGE_SEL_BIT = 4;
  localparam int          ATT2_BIT      = 3;
  localparam int          ATT1_BIT      = 2;
  localparam int          FOLLOW_BIT    = 1;
  localparam int          AGC_TEST_BIT  = 0;

  // ---------------------------------------------------------------
  // Coder test register fields
  // ---------------------------------------------------------------
  localparam int          RF_LVL_BIT    = 7;
  localparam int          IO_HI_BIT     = 3;
  localparam int          IO_LO_BIT     = 2;
  localparam int          DEC_TEST_BIT  = 1;
  localparam int          FAST_CLK_BIT  = 0;
  localparam logic [7:0]  CODER_WMASK   = 8'h8f;
  localparam logic [7:0]  TEST_MODE_MSK = 8'h0e;

  // ---------------------------------------------------------------
  // FIFO status fields and thresholds
  // ---------------------------------------------------------------
  localparam int          FIFO_DEPTH    = 12;
  localparam int          FIFO_HIGH_LVL = 9;
  localparam int          FIFO_LOW_LVL  = 3;
  localparam int          FHIGH_BIT     = 6;
  localparam int          FLOW_BIT      = 5;
  localparam int          FOVF_BIT      = 4;
  localparam int          CNT_W         = 4;

  // ---------------------------------------------------------------
  // Oscillator settling
  // ---------------------------------------------------------------
  localparam int          OSC_SETTLE_US = 200;
  localparam int          OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_FREQ_MHZ;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [LEVEL_W-1:0] envelope;
    logic [LEVEL_W-1:0] rf_amplitude;
  } level_in_t;

endpackage

//--- logic/reader_status_test_fifo_regs.sv
// Strength/oscillator status, two test registers and FIFO status, behind an APB slave.
// Assumes all inputs synchronous to clk_i; chip_enable_i low acts as a reset of the bank.
// Contract
// - Strength values stay valid from reception start until next transmit starts.
// - Strength capture keeps the peak envelope, readable after the packet ends.
// - Envelope is measured, except RF amplitude during the amplitude command.
// - Latched strength values clear when the next transmit action starts.
// - Each channel strength is a 3-bit code, seven steps of 4 dB.
// - Bits 2:0 hold main level, bits 5:3 auxiliary level, MSB on top.
// - Auxiliary channel uses secondary input, primary input when swap bit set.
// - Bit 6 shows the oscillator stable, about 200 us after start.
// - Both test registers reset to zero on reset or chip enable low.
// - Test bit 7 makes keying pin a digital decoder input.
// - Test bit 6 drives receiver subcarrier out on subcarrier pin.
// - Test bit 5 enables direct transmit keying through pin unless bit 6 is set, plus receiver reset.
// - Test bit 4 picks first or second amplifier stage for output.
// - Test bits 3 and 2 drop stage gain 6 dB, halve high-pass corner.
// - Test bit 0 shows gain control level in the main strength bits.
// - Decoder or I/O test bits enter test mode until stop clears them.
// - Coder test bit 0 clocks the coders at the fast rate.
// - FIFO status bit 7 always reads zero.
// - FIFO high flag bit 6 set at 9 bytes during reception.
// - FIFO low flag bit 5 set at 3 bytes during transmission.
// - Overflow bit 4 set when host writes more bytes than the FIFO holds.
// - Bits 3:0 report unread byte count minus one.
// - Combined FIFO event bit reflects high in reception, low in transmission.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module reader_status_test_fifo_regs #(
  parameter int OSC_SETTLE_CYCLES = reader_status_pkg::OSC_SETTLE_CYC,
  parameter int FIFO_DEPTH        = reader_status_pkg::FIFO_DEPTH
) (
  input  wire logic                                clk_i,             // 125 MHz clock
  input  wire logic                                rst_n_i,           // Sync reset, low
  input  wire logic                                chip_enable_i,     // Low resets bank
  input  wire reader_status_pkg::apb_req_t         apb_req_i,         // APB request
  output reader_status_pkg::apb_rsp_t              apb_rsp_o,         // APB response
  input  wire logic                                rx_active_i,       // Reception running
  input  wire logic                                tx_start_i,        // Transmit start pulse
  input  wire logic                                rf_level_cmd_i,    // Amplitude command
  input  wire reader_status_pkg::level_in_t        primary_receive_input_i,   // Primary levels
  input  wire reader_status_pkg::level_in_t        secondary_receive_input_i, // Secondary levels
  input  wire logic                                input_swap_i,      // Swap option bit
  input  wire logic [reader_status_pkg::LEVEL_W-1:0] agc_level_i,     // Gain control level
  input  wire logic                                keying_pin_i,      // Keying pin level
  input  wire logic                                decoder_data_i,    // Normal decoder data
  input  wire logic                                rx_subcarrier_i,   // Receiver subcarrier
  input  wire logic                                tx_modulation_i,   // Normal tx keying
  input  wire logic                                subcarrier_io_pin_i, // Pin level in
  output logic                                     subcarrier_io_pin_o, // Pin level out
  output logic                                     subcarrier_io_pin_oe_o, // Pin drive
  output logic                                     decoder_data_o,    // Decoder input
  output logic                                     tx_modulation_o,   // Transmit keying
  output logic                                     rx_reset_o,        // Receiver reset
  output logic                                     stage_select_o,    // 1 = second stage
  output logic                                     second_stage_attenuate_o, // -6 dB
  output logic                                     first_stage_attenuate_o,  // -6 dB
  output logic                                     follower_test_o,   // Follower test
  output logic                                     rf_level_test_enable_o, // RF level test
  input  wire logic                                stop_condition_i,  // Stop pulse
  output logic                                     test_mode_o,       // Test mode active
  output logic                                     coder_fast_clock_select_o, // Fast coder
  input  wire logic                                rx_mode_i,         // FIFO in receive use
  input  wire logic                                tx_mode_i,         // FIFO in transmit use
  input  wire logic                                fifo_push_i,       // Byte written
  input  wire logic                                fifo_pop_i,        // Byte read out
  input  wire logic                                fifo_clear_i,      // FIFO reset
  output logic                                     fifo_event_o       // High/low level flag
);

  // ---------------------------------------------------------------
  // Local types and helpers
  // ---------------------------------------------------------------
  localparam int LW = reader_status_pkg::LEVEL_W;
  localparam int CW = reader_status_pkg::CNT_W;
  localparam int OW = $clog2(OSC_SETTLE_CYCLES + 1);

  function automatic logic reg_hit(input logic [reader_status_pkg::ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[reader_status_pkg::ADDR_W-1:2] == idx[5:0]) && (addr[1:0] == 2'b00);
  endfunction

  logic          bank_rst;
  logic          wr_en;
  logic          rd_phase;
  logic          hit_strength;
  logic          hit_rx_test;
  logic          hit_coder;
  logic          hit_fifo;
  logic          hit_any;
  logic [7:0]    rx_test_reg;
  logic [7:0]    coder_reg;
  logic [OW-1:0] osc_cnt_reg;
  logic          osc_ok_reg;
  logic [CW-1:0] fifo_cnt_reg;
  logic [CW-1:0] fifo_cnt_next;
  logic          fifo_ovf_reg;
  logic [LW-1:0] main_src;
  logic [LW-1:0] aux_src;
  logic [LW-1:0] main_peak;
  logic [LW-1:0] aux_peak;
  logic [7:0]    strength_val;
  logic [7:0]    fifo_val;
  logic          fifo_high;
  logic          fifo_low;
  logic [7:0]    rd_val;
  logic [reader_status_pkg::DATA_W-1:0] prdata_reg;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign bank_rst     = !rst_n_i || !chip_enable_i;
  assign hit_strength = reg_hit(apb_req_i.paddr, reader_status_pkg::IDX_STRENGTH);
  assign hit_rx_test  = reg_hit(apb_req_i.paddr, reader_status_pkg::IDX_RX_TEST);
  assign hit_coder    = reg_hit(apb_req_i.paddr, reader_status_pkg::IDX_CODER);
  assign hit_fifo     = reg_hit(apb_req_i.paddr, reader_status_pkg::IDX_FIFO);
  assign hit_any      = hit_strength | hit_rx_test | hit_coder | hit_fifo;
  assign wr_en        = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
  assign rd_phase     = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;

  // Zero wait states; data captured during setup, so it is ready at access
  assign apb_rsp_o.pready  = 1'b1;
  assign apb_rsp_o.pslverr = apb_req_i.psel & apb_req_i.penable & ~hit_any;
  assign apb_rsp_o.prdata  = prdata_reg;

  // ---------------------------------------------------------------
  // Strength measurement
  // ---------------------------------------------------------------
  // Envelope normally, RF amplitude while the amplitude command runs
  assign main_src = rf_level_cmd_i ? primary_receive_input_i.rf_amplitude
                                   : primary_receive_input_i.envelope;
  assign aux_src  = input_swap_i
                  ? (rf_level_cmd_i ? primary_receive_input_i.rf_amplitude
                                    : primary_receive_input_i.envelope)
                  : (rf_level_cmd_i ? secondary_receive_input_i.rf_amplitude
                                    : secondary_receive_input_i.envelope);

  // Peak is held after reception ends and dropped at the next transmit
  peak_level_latch #(
    .W (LW)
  ) u_main_peak (
    .clk_i    (clk_i),
    .rst_n_i  (!bank_rst),
    .clear_i  (tx_start_i),
    .sample_i (rx_active_i | rf_level_cmd_i),
    .level_i  (main_src),
    .peak_o   (main_peak)
  );

  peak_level_latch #(
    .W (LW)
  ) u_aux_peak (
    .clk_i    (clk_i),
    .rst_n_i  (!bank_rst),
    .clear_i  (tx_start_i),
    .sample_i (rx_active_i | rf_level_cmd_i),
    .level_i  (aux_src),
    .peak_o   (aux_peak)
  );

  // ---------------------------------------------------------------
  // Oscillator settle timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (bank_rst) begin
      osc_cnt_reg <= '0;
      osc_ok_reg  <= 1'b0;
    end else if (osc_cnt_reg == OW'(OSC_SETTLE_CYCLES - 1)) begin
      osc_ok_reg  <= 1'b1;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + OW'(1);
    end
  end

  // Seven 4 dB steps on a 3-bit code per channel
  always_comb begin
    strength_val = 8'h00;
    strength_val[reader_status_pkg::MAIN_LSB +: LW] =
      rx_test_reg[reader_status_pkg::AGC_TEST_BIT] ? agc_level_i : main_peak;
    strength_val[reader_status_pkg::AUX_LSB +: LW] = aux_peak;
    strength_val[reader_status_pkg::OSC_OK_BIT] = osc_ok_reg;
  end

  // ---------------------------------------------------------------
  // Receiver test register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (bank_rst) begin
      rx_test_reg <= reader_status_pkg::RX_TEST_RST;
    end else if (wr_en && hit_rx_test) begin
      rx_test_reg <= apb_req_i.pwdata[7:0];
    end
  end

  assign decoder_data_o = rx_test_reg[reader_status_pkg::SUBC_IN_BIT]
                        ? keying_pin_i : decoder_data_i;
  assign subcarrier_io_pin_oe_o = rx_test_reg[reader_status_pkg::SUBC_OUT_BIT];
  assign subcarrier_io_pin_o    = rx_test_reg[reader_status_pkg::SUBC_OUT_BIT]
                                & rx_subcarrier_i;
  // Direct keying takes the pin as input unless the pin drives the subcarrier
  assign tx_modulation_o = (rx_test_reg[reader_status_pkg::DIRECT_BIT]
                           && !rx_test_reg[reader_status_pkg::SUBC_OUT_BIT])
                         ? subcarrier_io_pin_i : tx_modulation_i;
  assign rx_reset_o      = rx_test_reg[reader_status_pkg::DIRECT_BIT];
  assign stage_select_o  = rx_test_reg[reader_status_pkg::STAGE_SEL_BIT];
  assign second_stage_attenuate_o = rx_test_reg[reader_status_pkg::ATT2_BIT];
  assign first_stage_attenuate_o  = rx_test_reg[reader_status_pkg::ATT1_BIT];
  assign follower_test_o = rx_test_reg[reader_status_pkg::FOLLOW_BIT];

  // ---------------------------------------------------------------
  // Coder test register
  // ---------------------------------------------------------------
  // A host write in the stop cycle wins, so a fresh request is not lost
  always_ff @(posedge clk_i) begin
    if (bank_rst) begin
      coder_reg <= reader_status_pkg::CODER_RST;
    end else if (wr_en && hit_coder) begin
      coder_reg <= apb_req_i.pwdata[7:0] & reader_status_pkg::CODER_WMASK;
    end else if (stop_condition_i) begin
      coder_reg <= coder_reg & ~reader_status_pkg::TEST_MODE_MSK;
    end
  end

  assign test_mode_o = |(coder_reg & reader_status_pkg::TEST_MODE_MSK);
  assign coder_fast_clock_select_o = coder_reg[reader_status_pkg::FAST_CLK_BIT];
  assign rf_level_test_enable_o    = coder_reg[reader_status_pkg::RF_LVL_BIT];

  // ---------------------------------------------------------------
  // FIFO fill tracking
  // ---------------------------------------------------------------
  always_comb begin
    fifo_cnt_next = fifo_cnt_reg;
    if (fifo_push_i && !fifo_pop_i && (fifo_cnt_reg != CW'(FIFO_DEPTH))) begin
      fifo_cnt_next = fifo_cnt_reg + CW'(1);
    end else if (fifo_pop_i && !fifo_push_i && (fifo_cnt_reg != '0)) begin
      fifo_cnt_next = fifo_cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (bank_rst || fifo_clear_i) begin
      fifo_cnt_reg <= '0;
    end else begin
      fifo_cnt_reg <= fifo_cnt_next;
    end
  end

  // Overflow sticks until the FIFO is cleared; a push into a full FIFO in the clear cycle still sets it
  always_ff @(posedge clk_i) begin
    if (bank_rst) begin
      fifo_ovf_reg <= 1'b0;
    end else if (fifo_push_i && !fifo_pop_i && (fifo_cnt_reg == CW'(FIFO_DEPTH))) begin
      fifo_ovf_reg <= 1'b1;
    end else if (fifo_clear_i) begin
      fifo_ovf_reg <= 1'b0;
    end
  end

  assign fifo_high = rx_mode_i
                   && (fifo_cnt_reg >= CW'(reader_status_pkg::FIFO_HIGH_LVL));
  assign fifo_low  = tx_mode_i
                   && (fifo_cnt_reg <= CW'(reader_status_pkg::FIFO_LOW_LVL));
  assign fifo_event_o = fifo_high | fifo_low;

  always_comb begin
    fifo_val = 8'h00;
    fifo_val[reader_status_pkg::FHIGH_BIT] = fifo_high;
    fifo_val[reader_status_pkg::FLOW_BIT]  = fifo_low;
    fifo_val[reader_status_pkg::FOVF_BIT]  = fifo_ovf_reg;
    fifo_val[CW-1:0] = (fifo_cnt_reg == '0) ? '0 : fifo_cnt_reg - CW'(1);
  end

  // ---------------------------------------------------------------
  // Read mux; strength and FIFO status have no write path
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    if (hit_strength) begin
      rd_val = strength_val;
    end else if (hit_rx_test) begin
      rd_val = rx_test_reg;
    end else if (hit_coder) begin
      rd_val = coder_reg;
    end else if (hit_fifo) begin
      rd_val = fifo_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (bank_rst) begin
      prdata_reg <= '0;
    end else if (rd_phase) begin
      prdata_reg <= {24'h000000, rd_val};
    end
  end

endmodule

//--- tb/host_apb_model.sv
// Host side model: an APB master issuing one transfer at a time.
// Assumes its task is called just after a rising clock edge.
`timescale 1ns/1ps
module host_apb_model (
  input  wire logic                        clk_i, // Bus clock
  input  wire reader_status_pkg::apb_rsp_t rsp_i, // Slave answer
  output reader_status_pkg::apb_req_t      req_o  // Master request
);
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    req_o <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: w, pwdata: d};
    @(posedge clk_i);
    req_o.penable <= 1'h1;
    do @(posedge clk_i); while (rsp_i.pready !== 1'h1);
    q = rsp_i.prdata;
    e = rsp_i.pslverr;
    // Released lines show inverted values, not the old request
    req_o <= '{paddr: ~a, psel: 1'h0, penable: 1'h0, pwrite: ~w, pwdata: ~d};
    @(posedge clk_i);
  endtask
endmodule

//--- tb/reader_regs_asserts.sv
// Concurrent checks on the status, test and FIFO status register bank.
// Assumes binding to the bank's top module; sees its ports only.
`timescale 1ns/1ps
module reader_regs_asserts (
  input wire logic                        clk_i,                     // Clock
  input wire logic                        rst_n_i,                   // Reset, low
  input wire logic                        chip_enable_i,             // Bank enable
  input wire reader_status_pkg::apb_req_t apb_req_i,                 // APB request
  input wire reader_status_pkg::apb_rsp_t apb_rsp_o,                 // APB response
  input wire logic                        keying_pin_i,              // Keying pin
  input wire logic                        decoder_data_o,            // Decoder input
  input wire logic                        stage_select_o,            // Stage select
  input wire logic                        second_stage_attenuate_o,  // Stage two cut
  input wire logic                        test_mode_o,               // Test mode
  input wire logic                        stop_condition_i,          // Stop pulse
  input wire logic                        coder_fast_clock_select_o, // Fast coder
  input wire logic                        rx_mode_i,                 // Receive use
  input wire logic                        tx_mode_i,                 // Transmit use
  input wire logic                        fifo_event_o               // Level event
);
  wire logic [7:0] pa = apb_req_i.paddr;
  wire logic       acc = chip_enable_i && apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  bank_reset_a: assert property (!chip_enable_i |=> !test_mode_o && !stage_select_o)
    else $error("enable low left test bits set");
  keying_route_a: assert property (acc && pa == 8'h68 && apb_req_i.pwdata[7] |=>
    decoder_data_o == keying_pin_i) else $error("keying pin not routed");
  stage_sel_a: assert property (acc && pa == 8'h68 |=>
    stage_select_o == $past(apb_req_i.pwdata[4])) else $error("stage select wrong");
  stage_att_a: assert property (acc && pa == 8'h68 |=>
    second_stage_attenuate_o == $past(apb_req_i.pwdata[3])) else $error("attenuate wrong");
  stop_clear_a: assert property (stop_condition_i && !(acc && pa == 8'h6c) |=>
    !test_mode_o) else $error("stop left test mode");
  fast_clk_a: assert property (acc && pa == 8'h6c |=>
    coder_fast_clock_select_o == $past(apb_req_i.pwdata[0])) else $error("fast clock wrong");
  fifo_rsvd_a: assert property (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite
    && pa == 8'h70 |=> apb_rsp_o.prdata[31:7] == 25'h0) else $error("reserved bit set");
  idle_event_a: assert property (!rx_mode_i && !tx_mode_i |-> !fifo_event_o)
    else $error("level event without fifo use");
endmodule
bind reader_status_test_fifo_regs reader_regs_asserts reader_regs_asserts_inst (.*);

//--- tb/tb_reader_status_test_fifo_regs.sv
// Self-checking bench for the status, test and FIFO status register bank.
// Assumes the host model as APB master and a shortened oscillator settle count.
`timescale 1ns/1ps
module tb_reader_status_test_fifo_regs;
  logic clk_i = '0, rst_n_i = '0, chip_enable_i = '1, pin_drv = '0;
  reader_status_pkg::apb_req_t apb_req_i;
  reader_status_pkg::apb_rsp_t apb_rsp_o;
  reader_status_pkg::level_in_t primary_receive_input_i = '0, secondary_receive_input_i = '0;
  logic rx_active_i = '0, tx_start_i = '0, rf_level_cmd_i = '0, input_swap_i = '0;
  logic [2:0] agc_level_i = 3'h0;
  logic keying_pin_i = '0, decoder_data_i = '0, rx_subcarrier_i = '0, tx_modulation_i = '0;
  logic stop_condition_i = '0, rx_mode_i = '0, tx_mode_i = '0;
  logic fifo_push_i = '0, fifo_pop_i = '0, fifo_clear_i = '0;
  logic subcarrier_io_pin_o, subcarrier_io_pin_oe_o, decoder_data_o, tx_modulation_o;
  logic rx_reset_o, stage_select_o, second_stage_attenuate_o, first_stage_attenuate_o;
  logic follower_test_o, rf_level_test_enable_o, test_mode_o, coder_fast_clock_select_o;
  logic fifo_event_o;
  int error_cnt = 0, compares = 0;
  wire logic subcarrier_io_pin_i = subcarrier_io_pin_oe_o ? subcarrier_io_pin_o : pin_drv;
  reader_status_test_fifo_regs #(.OSC_SETTLE_CYCLES(20)) reader_status_test_fifo_regs_inst (.*);
  host_apb_model host_apb_model_inst (.clk_i(clk_i), .rsp_i(apb_rsp_o), .req_o(apb_req_i));
  initial forever #4 clk_i = ~clk_i;
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    host_apb_model_inst.xfer(1'h1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    logic e;
    host_apb_model_inst.xfer(1'h0, a, 32'h0, q, e);
    check(q[7:0], x);
    check({7'h0, e}, {7'h0, a == 8'h40});
  endtask
  task automatic fifo_ops(input int n, input logic push);
    repeat (n) begin
      @(posedge clk_i);
      fifo_push_i <= push;
      fifo_pop_i <= !push;
    end
    @(posedge clk_i);
    fifo_push_i <= '0;
    fifo_pop_i <= '0;
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_strength;
    repeat (20) @(posedge clk_i);
    primary_receive_input_i <= '{envelope: 3'h5, rf_amplitude: 3'h1};
    secondary_receive_input_i <= '{envelope: 3'h3, rf_amplitude: 3'h2};
    rx_active_i <= '1;
    repeat (3) @(posedge clk_i);
    rx_active_i <= '0;
    primary_receive_input_i <= '0;
    secondary_receive_input_i <= '0;
    repeat (2) @(posedge clk_i);
    rd(8'h3c, 8'h5d);
    tx_start_i <= '1;
    @(posedge clk_i);
    tx_start_i <= '0;
    rd(8'h3c, 8'h40);
    input_swap_i <= '1;
    primary_receive_input_i <= '{envelope: 3'h6, rf_amplitude: 3'h0};
    secondary_receive_input_i <= '{envelope: 3'h1, rf_amplitude: 3'h0};
    rx_active_i <= '1;
    repeat (2) @(posedge clk_i);
    rx_active_i <= '0;
    wr(8'h3c, 8'h00);
    rd(8'h3c, 8'h76);
    tx_start_i <= '1;
    @(posedge clk_i);
    tx_start_i <= '0;
    rf_level_cmd_i <= '1;
    primary_receive_input_i <= '{envelope: 3'h1, rf_amplitude: 3'h4};
    @(posedge clk_i);
    rf_level_cmd_i <= '0;
    rd(8'h3c, 8'h64);
  endtask
  task automatic t_regs;
    wr(8'h68, 8'hff);
    agc_level_i <= 3'h2;
    rd(8'h3c, 8'h62);
    rd(8'h68, 8'hff);
    wr(8'h6c, 8'hff);
    rd(8'h6c, 8'h8f);
    rd(8'h40, 8'h00);
    keying_pin_i <= '1;
    rx_subcarrier_i <= '1;
    @(negedge clk_i);
    check({subcarrier_io_pin_o, decoder_data_o, rx_reset_o, stage_select_o,
           second_stage_attenuate_o, first_stage_attenuate_o, follower_test_o,
           subcarrier_io_pin_oe_o}, 8'hff);
    check({4'h0, tx_modulation_o, rf_level_test_enable_o, test_mode_o,
           coder_fast_clock_select_o}, 8'h07);
    @(posedge clk_i);
    stop_condition_i <= '1;
    @(posedge clk_i);
    stop_condition_i <= '0;
    rd(8'h6c, 8'h81);
    chip_enable_i <= '0;
    @(posedge clk_i);
    chip_enable_i <= '1;
    rd(8'h68, 8'h00);
    rd(8'h6c, 8'h00);
    wr(8'h68, 8'h20);
    pin_drv <= '1;
    @(negedge clk_i);
    check({7'h0, tx_modulation_o}, 8'h01);
    @(posedge clk_i);
  endtask
  task automatic t_fifo;
    rx_mode_i <= '1;
    fifo_ops(9, 1'h1);
    rd(8'h70, 8'h48);
    check({7'h0, fifo_event_o}, 8'h01);
    fifo_ops(4, 1'h1);
    rd(8'h70, 8'h5b);
    rx_mode_i <= '0;
    tx_mode_i <= '1;
    fifo_ops(9, 1'h0);
    rd(8'h70, 8'h32);
    check({7'h0, fifo_event_o}, 8'h01);
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h32);
    fifo_clear_i <= '1;
    @(posedge clk_i);
    fifo_clear_i <= '0;
    rd(8'h70, 8'h20);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= '1;
    rd(8'h3c, 8'h00);
    t_strength();
    t_regs();
    t_fifo();
    close_out();
  end
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end
endmodule
